// ===== au_pkg.sv
// Package: register map, field layouts and state types of the serial core
package au_pkg;
	localparam logic [2:0] ADR_MODE = 3'h0;
	localparam logic [2:0] ADR_ERR = 3'h1;
	localparam logic [2:0] ADR_BAUD = 3'h2;
	localparam logic [2:0] ADR_TXD = 3'h3;
	localparam logic [2:0] ADR_RXD = 3'h4;
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] BAUD_RST = 8'h1f;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	localparam logic [1:0] PRE_EXT = 2'h0;
	localparam logic [1:0] PRE_DIV2 = 2'h1;
	localparam logic [1:0] PRE_DIV8 = 2'h2;
	localparam logic [4:0] PRE_MASK2 = 5'h01;
	localparam logic [4:0] PRE_MASK8 = 5'h07;
	localparam logic [4:0] PRE_MASK32 = 5'h1f;
	localparam logic [2:0] LAST_BIT8 = 3'h7;
	localparam logic [2:0] LAST_BIT7 = 3'h6;
	localparam logic [7:0] MASK7 = 8'h7f;

	typedef struct packed {
		logic power;
		logic txe;
		logic rxe;
		logic [1:0] par;
		logic cl;
		logic sl;
		logic fixed;
	} au_mode_s;

	typedef struct packed {
		logic [1:0] pre;
		logic rsvd;
		logic [4:0] k;
	} au_baud_s;

	typedef struct packed {
		logic pe;
		logic fe;
		logic ove;
	} au_err_s;

	typedef enum logic [4:0] {
		TX_IDLE = 5'h01,
		TX_START = 5'h02,
		TX_DATA = 5'h04,
		TX_PAR = 5'h08,
		TX_STOP = 5'h10
	} au_tx_e;

	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} au_rx_e;
endpackage : au_pkg

// ===== au_baud_cnt.sv
// Five-bit programmable baud counter, one per direction
module au_baud_cnt (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic clr_i,
	input wire logic tick_i,
	input wire logic [4:0] k_i,
	output logic term_o
);
	logic [4:0] cnt_r;
	logic [4:0] last;

	// Wraps after k base ticks, i.e. one half bit period
	assign last = k_i - 5'h01;
	assign term_o = tick_i && !clr_i && (cnt_r == last);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || clr_i) begin
			cnt_r <= 5'h00;
		end else if (tick_i) begin
			if (cnt_r == last) begin
				cnt_r <= 5'h00;
			end else begin
				cnt_r <= cnt_r + 5'h01;
			end
		end
	end
endmodule : au_baud_cnt

// ===== au_uart.sv
// Asynchronous serial transceiver core with classic Wishbone register slave
// Functional notes
// R1: Frame is start, 7 or 8 data LSB first, optional parity, 1 or 2 stops.
// R2: Power off stops all; transmit and receive enables claim their pins separately.
// R3: Even parity: transmitted ones even; receiver flags odd count.
// R4: Odd parity: transmitted ones odd; receiver flags even count.
// R5: Zero parity sends 0 and is never checked.
// R6: No parity: no parity bit sent or expected, never an error.
// R7: Transmit needs power then enable; each data write starts one frame.
// R8: Start, data LSB first, parity, stops; done pulse after last stop.
// R9: Line stays idle after a frame until the next data write.
// R10: Software waits for transmit done before writing the next byte.
// R11: Filtered falling edge starts receive counter; low at half bit confirms start.
// R12: Bits shift in at baud rate; at stop raise done, buffer unless overrun.
// R13: Parity error does not abort; frame runs to stop, shared done pulse.
// R14: Receiver checks exactly one stop bit and ignores a second.
// R15: Parity, framing and overrun errors, each raises the receive pulse.
// R16: Reading error status returns the flags and clears them.
// R17: After an error software reads status, then the receive buffer.
// R18: Receive input filtered on base clock; level changes when two samples agree.
// R19: Two-bit prescale select picks base clock; gated off when power clear.
// R20: Transmit and receive have independent five-bit baud counters.
// R21: Transmit counter held zero unless power and enable; cleared on data write.
// R22: Receive counter held zero when off; runs from start bit for one frame.
// R23: Divider k in bits 4..0, 8 to 31; bit rate is base over 2k.
// R24: Power clear resets the block, status, transmit and receive data; input high.
// R25: Clearing an enable synchronously resets that direction's circuit.
// R26: Software keeps k at 8 or more and changes it only when disabled.
// R27: Mode register holds parity field, length bit and stop bit.
// R28: Each bit sampled once per period, aligned to the confirmed start sample.
//
// Added by the designer: the address map and the Wishbone interface to the registers.
module au_uart (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_tick_i,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oen_o,
	output logic serial_in_claim_o,
	output logic transmit_done_irq_o,
	output logic receive_done_irq_o
);
	au_pkg::au_mode_s serial_mode_register;
	au_pkg::au_baud_s baud_control_register;
	au_pkg::au_err_s receive_error_status;
	au_pkg::au_err_s err_set;
	au_pkg::au_tx_e tx_st_r;
	au_pkg::au_rx_e rx_st_r;
	logic [7:0] transmit_shift_register;
	logic [7:0] receive_buffer;
	logic [7:0] receive_shift_register;
	logic [7:0] tx_sh_r;
	logic [7:0] rx_word;
	logic [4:0] pre_cnt_r;
	logic [4:0] pre_mask;
	logic [2:0] tx_idx_r;
	logic [2:0] rx_idx_r;
	logic [2:0] last_idx;
	logic [31:0] rd_data;
	logic wb_req;
	logic wr_lane0;
	logic rd_err;
	logic rd_rxd;
	logic base_tick;
	logic tx_run;
	logic rx_run;
	logic tx_load;
	logic tx_clr;
	logic tx_term;
	logic tx_half_r;
	logic tx_bit_end;
	logic tx_line_r;
	logic tx_stop2_r;
	logic tx_done;
	logic par_bit;
	logic rx_pin;
	logic smp_a_r;
	logic filt_r;
	logic filt_prev_r;
	logic rx_fall;
	logic rx_clr;
	logic rx_term;
	logic rx_half_r;
	logic rx_sample;
	logic rx_acc_r;
	logic rx_done;
	logic rx_full_r;

	function automatic logic odd8(input logic [7:0] v);
		odd8 = ^v;
	endfunction : odd8

	// Register slave: one wait state, ack drops after each answer
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_lane0 = wb_req && wb_we_i && wb_sel_i[0];
	assign rd_err = wb_req && !wb_we_i && (wb_adr_i[4:2] == au_pkg::ADR_ERR);
	assign rd_rxd = wb_req && !wb_we_i && (wb_adr_i[4:2] == au_pkg::ADR_RXD);

	always_comb begin
		case (wb_adr_i[4:2])
			au_pkg::ADR_MODE: rd_data = {24'h000000, serial_mode_register};
			au_pkg::ADR_ERR: rd_data = {29'h00000000, receive_error_status};
			au_pkg::ADR_BAUD: rd_data = {24'h000000, baud_control_register};
			au_pkg::ADR_TXD: rd_data = {24'h000000, transmit_shift_register};
			au_pkg::ADR_RXD: rd_data = {24'h000000, receive_buffer};
			default: rd_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				wb_dat_o <= rd_data;
			end
		end
	end

	// Mode register; the lowest bit always reads one
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			serial_mode_register <= au_pkg::MODE_RST;
		end else if (wr_lane0 && wb_adr_i[4:2] == au_pkg::ADR_MODE) begin
			serial_mode_register <= wb_dat_i[7:0] | au_pkg::MODE_RST; // R27
		end
	end

	// Divider may only be changed while both directions are off
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			baud_control_register <= au_pkg::BAUD_RST;
		end else if (wr_lane0 && wb_adr_i[4:2] == au_pkg::ADR_BAUD) begin
			baud_control_register <= {wb_dat_i[7:6], 1'b0, wb_dat_i[4:0]}; // R23
		end
	end

	assign tx_run = serial_mode_register.power && serial_mode_register.txe;
	assign rx_run = serial_mode_register.power && serial_mode_register.rxe;
	assign last_idx = serial_mode_register.cl ? au_pkg::LAST_BIT8
		: au_pkg::LAST_BIT7;

	// Prescaler; base tick is stopped entirely while power is clear
	always_comb begin
		case (baud_control_register.pre)
			au_pkg::PRE_DIV2: pre_mask = au_pkg::PRE_MASK2;
			au_pkg::PRE_DIV8: pre_mask = au_pkg::PRE_MASK8;
			default: pre_mask = au_pkg::PRE_MASK32;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !serial_mode_register.power) begin
			pre_cnt_r <= 5'h00;
		end else begin
			pre_cnt_r <= pre_cnt_r + 5'h01;
		end
	end

	assign base_tick = serial_mode_register.power
		&& ((baud_control_register.pre == au_pkg::PRE_EXT) ? ext_tick_i
		: ((pre_cnt_r & pre_mask) == pre_mask)); // R19

	// Pin ownership
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			serial_out_pin_oen_o <= 1'b1;
			serial_in_claim_o <= 1'b0;
		end else begin
			serial_out_pin_oen_o <= !tx_run; // R2
			serial_in_claim_o <= rx_run; // R2
		end
	end

	// Transmit side
	assign tx_load = tx_run && wr_lane0
		&& (wb_adr_i[4:2] == au_pkg::ADR_TXD) && (tx_st_r == au_pkg::TX_IDLE);
	assign tx_clr = !tx_run || tx_load; // R21

	au_baud_cnt u_tx_cnt (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.clr_i(tx_clr),
		.tick_i(base_tick),
		.k_i(baud_control_register.k),
		.term_o(tx_term)
	); // R20

	// Bit period is two counter wraps, giving base over 2k
	assign tx_bit_end = tx_term && tx_half_r; // R23

	always_comb begin
		case (serial_mode_register.par)
			au_pkg::PAR_EVEN: par_bit = odd8(tx_sh_r); // R3
			au_pkg::PAR_ODD: par_bit = !odd8(tx_sh_r); // R4
			default: par_bit = 1'b0; // R5
		endcase
	end

	// Data is kept unshifted in the holding register for readback
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !serial_mode_register.power) begin
			transmit_shift_register <= 8'h00; // R24
		end else if (tx_load) begin
			transmit_shift_register <= wb_dat_i[7:0]; // R7
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !tx_run) begin
			tx_st_r <= au_pkg::TX_IDLE; // R25
			tx_line_r <= 1'b1;
			tx_half_r <= 1'b0;
			tx_idx_r <= 3'h0;
			tx_sh_r <= 8'h00;
			tx_stop2_r <= 1'b0;
		end else if (tx_load) begin
			tx_st_r <= au_pkg::TX_START; // R7
			tx_line_r <= 1'b0;
			tx_half_r <= 1'b0;
			tx_idx_r <= 3'h0;
			tx_sh_r <= serial_mode_register.cl ? wb_dat_i[7:0]
				: (wb_dat_i[7:0] & au_pkg::MASK7);
			tx_stop2_r <= 1'b0;
		end else begin
			if (tx_term) begin
				tx_half_r <= !tx_half_r;
			end
			if (tx_bit_end) begin
				case (tx_st_r)
					au_pkg::TX_START: begin
						tx_st_r <= au_pkg::TX_DATA;
						tx_line_r <= tx_sh_r[0]; // R8
					end
					au_pkg::TX_DATA: begin
						if (tx_idx_r == last_idx) begin
							if (serial_mode_register.par == au_pkg::PAR_NONE) begin
								tx_st_r <= au_pkg::TX_STOP; // R6
								tx_line_r <= 1'b1;
							end else begin
								tx_st_r <= au_pkg::TX_PAR;
								tx_line_r <= par_bit; // R1
							end
						end else begin
							tx_idx_r <= tx_idx_r + 3'h1;
							tx_line_r <= tx_sh_r[tx_idx_r + 3'h1]; // R8
						end
					end
					au_pkg::TX_PAR: begin
						tx_st_r <= au_pkg::TX_STOP;
						tx_line_r <= 1'b1;
					end
					au_pkg::TX_STOP: begin
						if (serial_mode_register.sl && !tx_stop2_r) begin
							tx_stop2_r <= 1'b1; // R1
						end else begin
							tx_st_r <= au_pkg::TX_IDLE; // R9
						end
					end
					default: begin
						tx_st_r <= au_pkg::TX_IDLE;
						tx_line_r <= 1'b1;
					end
				endcase
			end
		end
	end

	assign tx_done = tx_run && tx_bit_end && (tx_st_r == au_pkg::TX_STOP)
		&& !(serial_mode_register.sl && !tx_stop2_r);

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			serial_out_pin_o <= 1'b1;
			transmit_done_irq_o <= 1'b0;
		end else begin
			serial_out_pin_o <= tx_line_r || !tx_run;
			transmit_done_irq_o <= tx_done; // R8
		end
	end

	// Receive noise filter: input forced high while power is clear
	assign rx_pin = serial_in_pin_i || !serial_mode_register.power; // R24

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !serial_mode_register.power) begin
			smp_a_r <= 1'b1;
			filt_r <= 1'b1;
		end else if (base_tick) begin
			smp_a_r <= rx_pin;
			if (rx_pin == smp_a_r) begin
				filt_r <= smp_a_r; // R18
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			filt_prev_r <= 1'b1;
		end else begin
			filt_prev_r <= filt_r;
		end
	end

	assign rx_fall = filt_prev_r && !filt_r;
	// Counter idles at zero between frames and when off
	assign rx_clr = !rx_run || (rx_st_r == au_pkg::RX_IDLE); // R22

	au_baud_cnt u_rx_cnt (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.clr_i(rx_clr),
		.tick_i(base_tick),
		.k_i(baud_control_register.k),
		.term_o(rx_term)
	); // R20

	assign rx_sample = rx_term && rx_half_r; // R28
	assign rx_word = serial_mode_register.cl ? receive_shift_register
		: {1'b0, receive_shift_register[7:1]};
	assign rx_done = rx_run && rx_sample && (rx_st_r == au_pkg::RX_STOP);

	always_comb begin
		err_set.pe = rx_done && ((serial_mode_register.par == au_pkg::PAR_EVEN
			&& rx_acc_r) || (serial_mode_register.par == au_pkg::PAR_ODD
			&& !rx_acc_r)); // R3 R4 R5 R6
		err_set.fe = rx_done && !filt_r; // R15
		err_set.ove = rx_done && rx_full_r; // R15
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !rx_run) begin
			rx_st_r <= au_pkg::RX_IDLE; // R25
			rx_half_r <= 1'b0;
			rx_idx_r <= 3'h0;
			rx_acc_r <= 1'b0;
			receive_shift_register <= 8'h00;
		end else begin
			if (rx_term) begin
				rx_half_r <= !rx_half_r;
			end
			case (rx_st_r)
				au_pkg::RX_IDLE: begin
					if (rx_fall) begin
						rx_st_r <= au_pkg::RX_START; // R11
					end
				end
				au_pkg::RX_START: begin
					if (rx_term) begin
						rx_half_r <= 1'b0;
						rx_idx_r <= 3'h0;
						rx_acc_r <= 1'b0;
						rx_st_r <= filt_r ? au_pkg::RX_IDLE : au_pkg::RX_DATA; // R11
					end
				end
				au_pkg::RX_DATA: begin
					if (rx_sample) begin
						receive_shift_register <= {filt_r,
							receive_shift_register[7:1]}; // R12
						rx_acc_r <= rx_acc_r ^ filt_r;
						rx_idx_r <= rx_idx_r + 3'h1;
						if (rx_idx_r == last_idx) begin
							rx_st_r <= (serial_mode_register.par == au_pkg::PAR_NONE)
								? au_pkg::RX_STOP : au_pkg::RX_PAR; // R6
						end
					end
				end
				au_pkg::RX_PAR: begin
					if (rx_sample) begin
						rx_acc_r <= rx_acc_r ^ filt_r;
						rx_st_r <= au_pkg::RX_STOP; // R13
					end
				end
				au_pkg::RX_STOP: begin
					// Only one stop is checked; a second stays high and is skipped
					if (rx_sample) begin
						rx_st_r <= au_pkg::RX_IDLE; // R14
					end
				end
				default: rx_st_r <= au_pkg::RX_IDLE;
			endcase
		end
	end

	// Receive buffer keeps the old byte on overrun
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !serial_mode_register.power) begin
			receive_buffer <= 8'h00; // R24
			rx_full_r <= 1'b0;
		end else if (rx_done) begin
			rx_full_r <= 1'b1;
			if (!rx_full_r) begin
				receive_buffer <= rx_word; // R12
			end
		end else if (rd_rxd) begin
			rx_full_r <= 1'b0;
		end
	end

	// Read clears all flags; a flag set in the same cycle survives
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !serial_mode_register.power) begin
			receive_error_status <= 3'h0; // R24
		end else if (rd_err) begin
			receive_error_status <= err_set; // R16
		end else begin
			receive_error_status <= receive_error_status | err_set; // R15
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			receive_done_irq_o <= 1'b0;
		end else begin
			receive_done_irq_o <= rx_done; // R13
		end
	end
endmodule : au_uart

// ===== au_uart_sva.sv
// Checker: bus, pin ownership and pulse properties of the serial core
module au_uart_sva (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic ext_tick_i,
	input wire logic serial_in_pin_i,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oen_o,
	input wire logic serial_in_claim_o,
	input wire logic transmit_done_irq_o,
	input wire logic receive_done_irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] hm_r;
	logic [2:0] hm1_r;
	logic [2:0] hm2_r;
	logic tk;
	logic st;
	logic txon;
	logic rxon;
	assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Mode stable for two edges, so registered pin outputs have settled
	assign st = (hm_r == hm1_r) && (hm1_r == hm2_r);
	assign txon = hm_r[2] & hm_r[1];
	assign rxon = hm_r[2] & hm_r[0];
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			hm_r <= 3'h0;
		end else if (tk && wb_we_i && wb_sel_i[0]
			&& wb_adr_i[4:2] == au_pkg::ADR_MODE) begin
			hm_r <= wb_dat_i[7:5];
		end
	end
	always_ff @(posedge mclk_i) begin
		hm1_r <= sys_rst_i ? 3'h0 : hm_r;
		hm2_r <= sys_rst_i ? 3'h0 : hm1_r;
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	ack_lat_a: assert property (tk |=> wb_ack_o)
		else $error("bus request not acknowledged");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	rd_hi_a: assert property (wb_ack_o && !wb_we_i |->
		wb_dat_o[31:8] == 24'h0) else $error("read upper bits set");
	tx_own_a: assert property (st |-> serial_out_pin_oen_o == !txon)
		else $error("transmit pin ownership wrong");
	rx_own_a: assert property (st |-> serial_in_claim_o == rxon)
		else $error("receive pin ownership wrong");
	out_idle_a: assert property (st && !txon |->
		serial_out_pin_o && !transmit_done_irq_o)
		else $error("disabled transmitter active");
	txd_pulse_a: assert property (transmit_done_irq_o |=>
		!transmit_done_irq_o) else $error("transmit done too long");
	txd_line_a: assert property (transmit_done_irq_o |->
		serial_out_pin_o) else $error("line low at transmit done");
	rxd_pulse_a: assert property (receive_done_irq_o |=>
		!receive_done_irq_o) else $error("receive done too long");
	rx_off_a: assert property (st && !rxon |-> !receive_done_irq_o)
		else $error("disabled receiver signalled");
	cover property (transmit_done_irq_o);
	cover property (receive_done_irq_o);
	cover property (tk && !wb_we_i && wb_adr_i[4:2] == au_pkg::ADR_ERR);
endmodule : au_uart_sva
bind au_uart au_uart_sva chk_u (.mclk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.ext_tick_i, .serial_in_pin_i, .serial_out_pin_o, .serial_out_pin_oen_o,
	.serial_in_claim_o, .transmit_done_irq_o, .receive_done_irq_o);

// ===== au_line_peer.sv
// Remote serial partner: decodes the core's frames and sends frames to it
module au_line_peer (
	input wire logic clk_i,
	input wire logic [9:0] bit_i,
	input wire logic line_i,
	output logic line_o,
	input wire logic [1:0] par_i,
	input wire logic cl_i,
	output logic [7:0] got_o,
	output logic par_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] g;
	logic p;
	initial line_o = 1'b1;
	// Sampling mid-bit tolerates a cycle or two of start skew
	always begin
		@(negedge line_i);
		repeat (bit_i / 2) @(posedge clk_i);
		if (line_i === 1'b0) begin
			g = 8'h0;
			for (int i = 0; i < 8; i++) begin
				if (i < 7 || cl_i) begin
					repeat (bit_i) @(posedge clk_i);
					g[i] = line_i;
				end
			end
			p = 1'b0;
			if (par_i != au_pkg::PAR_NONE) begin
				repeat (bit_i) @(posedge clk_i);
				p = line_i;
			end
			repeat (bit_i) @(posedge clk_i);
			// A missing stop bit corrupts the byte so the compare fails
			got_o = line_i ? g : ~g;
			par_o = p;
		end
	end
	task send(input logic [7:0] d, input int nb, input logic pe,
		input logic pb, input logic st);
		line_o <= 1'b0;
		repeat (bit_i) @(posedge clk_i);
		for (int i = 0; i < nb; i++) begin
			line_o <= d[i];
			repeat (bit_i) @(posedge clk_i);
		end
		if (pe) begin
			line_o <= pb;
			repeat (bit_i) @(posedge clk_i);
		end
		line_o <= st;
		repeat (bit_i) @(posedge clk_i);
		line_o <= 1'b1;
		repeat (bit_i) @(posedge clk_i);
	endtask : send
endmodule : au_line_peer

// ===== au_uart_tb_top.sv
// Testbench: register access, frames both ways and receive error flags
module au_uart_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0;
	logic rst = 1;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic tick = 0;
	logic [4:0] adr = 5'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] dq;
	logic ack, so, soe, clm, txd, rxd, rx_line, tx_line, pp;
	logic [7:0] pg;
	logic [1:0] pm = 2'h0;
	logic pcl = 1'b1;
	logic [9:0] bl = 10'h020;
	int n_errors = 0;
	int samples_checked = 0;
	always #50 clk = ~clk;
	always @(posedge clk) tick <= ~tick;
	// Pull-up on the transmit wire while the core does not drive it
	assign tx_line = soe ? 1'b1 : so;
	au_uart dut_u (.mclk_i(clk), .sys_rst_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_tick_i(tick),
		.serial_in_pin_i(rx_line), .serial_out_pin_o(so),
		.serial_out_pin_oen_o(soe), .serial_in_claim_o(clm),
		.transmit_done_irq_o(txd), .receive_done_irq_o(rxd));
	au_line_peer peer_u (.clk_i(clk), .bit_i(bl), .line_i(tx_line),
		.line_o(rx_line), .par_i(pm), .cl_i(pcl), .got_o(pg), .par_o(pp));
	task stop_test;
		if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task chk_reg(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %0t reg %h exp %h", $time, g, e);
		end
	endtask : chk_reg
	task chk_line(input logic [8:0] g, input logic [8:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %0t line %h exp %h", $time, g, e);
		end
	endtask : chk_line
	task wb(input logic w, input logic [2:0] a, input logic [7:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {a, 2'b00};
		dat <= {24'h0, d};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_errors++;
			stop_test;
		end
		dq = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task rd(input logic [2:0] a, input logic [31:0] e);
		wb(1'b0, a, 8'h0);
		chk_reg(dq, e);
	endtask : rd
	task wt(output int n, input logic r);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((r ? rxd : txd) !== 1'b1 && n < 6000);
		if (n >= 6000) begin
			n_errors++;
			stop_test;
		end
	endtask : wt
	function automatic logic pty(input logic [1:0] p, input logic [7:0] d);
		case (p)
			au_pkg::PAR_EVEN: return ^d;
			au_pkg::PAR_ODD: return ~^d;
			default: return 1'b0;
		endcase
	endfunction : pty
	// Prescale and divider only change with the core powered down
	task cfg(input logic [7:0] b, input logic [7:0] m);
		wb(1'b1, au_pkg::ADR_MODE, 8'h0);
		wb(1'b1, au_pkg::ADR_BAUD, b);
		wb(1'b1, au_pkg::ADR_MODE, m);
		pm = m[4:3];
		pcl = m[2];
		// Bit period is 2k base ticks; the external tick comes every 2 cycles
		bl = 10'(2 * b[4:0] * (b[7] ? (b[6] ? 32 : 8) : 2));
	endtask : cfg
	task tx(input logic [7:0] d, input int nb);
		int n;
		logic [7:0] e;
		e = pcl ? d : d & au_pkg::MASK7;
		wb(1'b1, au_pkg::ADR_TXD, d);
		wt(n, 1'b0);
		chk_line({pp, pg}, {pty(pm, e), e});
		// Start bit may be one prescale period short of a full bit
		chk_reg({31'h0, n >= nb * bl - bl / 16 - 4 && n <= nb * bl + 4},
			32'h1);
		rd(au_pkg::ADR_TXD, {24'h0, d});
	endtask : tx
	task rx(input logic [7:0] d, input int nb, input logic pe,
		input logic pb, input logic st);
		int n;
		fork
			peer_u.send(d, nb, pe, pb, st);
			wt(n, 1'b1);
		join
	endtask : rx
	initial begin
		logic [7:0] m;
		logic [7:0] d;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(au_pkg::ADR_MODE, 32'h01);
		rd(au_pkg::ADR_BAUD, 32'h1f);
		rd(3'h5, 32'h0);
		rd(au_pkg::ADR_ERR, 32'h0);
		wb(1'b1, au_pkg::ADR_BAUD, 8'h68);
		rd(au_pkg::ADR_BAUD, 32'h48);
		for (int p = 0; p < 4; p++) begin
			m = {3'h7, p[1:0], 1'b1, p[0], 1'b1};
			d = 8'hc5 ^ 8'(p);
			cfg(p[0] ? 8'h08 : 8'h48, m);
			rd(au_pkg::ADR_MODE, {24'h0, m});
			tx(d, 10 + (p != 0) + p[0]);
			rx(d, 8, p != 0, p == 1 ? 1'b1 : pty(p[1:0], d), 1'b1);
			rd(au_pkg::ADR_ERR, 32'h0);
			rd(au_pkg::ADR_RXD, {24'h0, d});
		end
		cfg(8'h48, 8'hf3);
		tx(8'hb6, 11);
		rx(8'h36, 7, 1'b1, pty(au_pkg::PAR_ODD, 8'h36), 1'b1);
		rd(au_pkg::ADR_ERR, 32'h0);
		rd(au_pkg::ADR_RXD, 32'h36);
		cfg(8'h88, 8'hc5);
		tx(8'h87, 10);
		cfg(8'hc8, 8'hc5);
		tx(8'h3a, 10);
		cfg(8'h48, 8'hfd);
		rx(8'h5a, 8, 1'b1, ~pty(au_pkg::PAR_EVEN, 8'h5a), 1'b1);
		rd(au_pkg::ADR_ERR, 32'h4);
		rd(au_pkg::ADR_ERR, 32'h0);
		rd(au_pkg::ADR_RXD, 32'h5a);
		rx(8'h3c, 8, 1'b1, pty(au_pkg::PAR_EVEN, 8'h3c), 1'b0);
		rd(au_pkg::ADR_ERR, 32'h2);
		wb(1'b0, au_pkg::ADR_RXD, 8'h0);
		rx(8'h11, 8, 1'b1, pty(au_pkg::PAR_EVEN, 8'h11), 1'b1);
		rx(8'h22, 8, 1'b1, pty(au_pkg::PAR_EVEN, 8'h22), 1'b1);
		rd(au_pkg::ADR_ERR, 32'h1);
		rd(au_pkg::ADR_RXD, 32'h11);
		rx(8'h33, 8, 1'b1, pty(au_pkg::PAR_EVEN, 8'h33), 1'b1);
		wb(1'b1, au_pkg::ADR_MODE, 8'h0);
		rd(au_pkg::ADR_RXD, 32'h0);
		rd(au_pkg::ADR_TXD, 32'h0);
		stop_test;
	end
endmodule : au_uart_tb_top
